// ==== core/exd_pkg.sv ====
package exd_pkg;

  // Operation selects presented by instruction decode
  typedef enum logic [2:0] {
    EXD_OP_NONE,
    EXD_OP_BYTE_EXCH,
    EXD_OP_DIGIT_EXCH,
    EXD_OP_XOR_A,
    EXD_OP_XOR_DIR
  } exd_op_t;

  // Source of the second exclusive-OR operand
  typedef enum logic [1:0] {
    EXD_SRC_REG,
    EXD_SRC_DIR,
    EXD_SRC_IND,
    EXD_SRC_IMM
  } exd_src_t;

  localparam int unsigned EXD_DATA_W     = 8;
  localparam int unsigned EXD_NIB_W      = 4;
  localparam logic [7:0]  EXD_ACC_RST    = 8'h00;
  localparam logic [7:0]  EXD_WDATA_RST  = 8'h00;
  localparam logic [7:0]  EXD_WADDR_RST  = 8'h00;
  localparam logic [2:0]  EXD_EXCH_CYCLES = 3'h1;

endpackage : exd_pkg

// ==== core/exd_datapath.sv ====
// Function
// RL1 - Byte exchange loads accumulator from indirect RAM byte and writes old accumulator there.
// RL2 - Digit exchange swaps low nibbles of accumulator and indirect RAM byte.
// RL3 - Digit exchange keeps both high nibbles and changes no status flag.
// RL4 - Exclusive-OR writes bitwise XOR of operands to destination, flags unchanged.
// RL5 - Six XOR forms: A with reg/direct/indirect/immediate; direct with A/immediate.
// RL6 - XOR to an output port reads the port latch, not the pins.
// RL7 - XOR to direct byte inverts exactly the mask bits, any RAM or register.
// RL8 - Indirect byte exchange and digit exchange finish in one machine cycle.
`timescale 1ns/1ps
`default_nettype none

module exd_datapath
  import exd_pkg::*;
#(
  parameter int unsigned DATA_W = EXD_DATA_W
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  input  wire exd_op_t           OP_I,
  input  wire exd_src_t          SRC_I,
  input  wire logic [DATA_W-1:0] PTR_ADDR_I,
  input  wire logic [DATA_W-1:0] IND_DATA_I,
  input  wire logic [DATA_W-1:0] REG_DATA_I,
  input  wire logic [DATA_W-1:0] DIR_ADDR_I,
  input  wire logic [DATA_W-1:0] DIR_DATA_I,
  input  wire logic              DIR_IS_PORT_I,
  input  wire logic [DATA_W-1:0] PORT_LATCH_I,
  input  wire logic [DATA_W-1:0] IMM_DATA_I,
  output logic      [DATA_W-1:0] ACC_O,
  output logic                   WR_EN_O,
  output logic                   WR_IND_O,
  output logic      [DATA_W-1:0] WR_ADDR_O,
  output logic      [DATA_W-1:0] WR_DATA_O,
  output logic                   DONE_O
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic              wr_en;
    logic              wr_ind;
    logic [DATA_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic              done;
  } exd_state_t;

  exd_state_t st_reg;
  exd_state_t st_next;
  logic [DATA_W-1:0] dir_orig;
  logic [DATA_W-1:0] src_val;

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  always_comb begin
    dir_orig = DIR_IS_PORT_I ? PORT_LATCH_I : DIR_DATA_I; // RL6
    case (SRC_I) // RL5
      EXD_SRC_REG: src_val = REG_DATA_I;
      EXD_SRC_DIR: src_val = dir_orig;
      EXD_SRC_IND: src_val = IND_DATA_I;
      EXD_SRC_IMM: src_val = IMM_DATA_I;
      default:     src_val = IMM_DATA_I;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next        = st_reg;
    st_next.wr_en  = 1'b0;
    st_next.wr_ind = 1'b0;
    st_next.done   = 1'b0;
    case (OP_I)
      EXD_OP_BYTE_EXCH: begin
        st_next.acc     = IND_DATA_I; // RL1
        st_next.wr_en   = 1'b1;
        st_next.wr_ind  = 1'b1;
        st_next.wr_addr = PTR_ADDR_I;
        st_next.wr_data = st_reg.acc; // RL1
        st_next.done    = 1'b1; // RL8
      end
      EXD_OP_DIGIT_EXCH: begin
        st_next.acc     = {st_reg.acc[DATA_W-1:EXD_NIB_W],
                           IND_DATA_I[EXD_NIB_W-1:0]}; // RL2
        st_next.wr_en   = 1'b1;
        st_next.wr_ind  = 1'b1;
        st_next.wr_addr = PTR_ADDR_I;
        st_next.wr_data = {IND_DATA_I[DATA_W-1:EXD_NIB_W],
                           st_reg.acc[EXD_NIB_W-1:0]}; // RL3
        st_next.done    = 1'b1; // RL8
      end
      EXD_OP_XOR_A: begin
        st_next.acc  = st_reg.acc ^ src_val; // RL4
        st_next.done = 1'b1;
      end
      EXD_OP_XOR_DIR: begin
        st_next.wr_en   = 1'b1;
        st_next.wr_addr = DIR_ADDR_I;
        st_next.wr_data = dir_orig ^ ((SRC_I == EXD_SRC_IMM) ? IMM_DATA_I
                                                             : st_reg.acc); // RL7
        st_next.done    = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg <= '{acc: DATA_W'(EXD_ACC_RST), wr_en: 1'b0, wr_ind: 1'b0,
                  wr_addr: DATA_W'(EXD_WADDR_RST), wr_data: DATA_W'(EXD_WDATA_RST),
                  done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ACC_O     = st_reg.acc;
  assign WR_EN_O   = st_reg.wr_en;
  assign WR_IND_O  = st_reg.wr_ind;
  assign WR_ADDR_O = st_reg.wr_addr;
  assign WR_DATA_O = st_reg.wr_data;
  assign DONE_O    = st_reg.done;

  // ****************************************************************
  // Exchange checks
  // ****************************************************************
  AST_BYTE_SWAP: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL1
    OP_I == EXD_OP_BYTE_EXCH |=> ACC_O == $past(IND_DATA_I) && WR_DATA_O == $past(ACC_O)
      && WR_EN_O && WR_IND_O && WR_ADDR_O == $past(PTR_ADDR_I))
    else $error("byte exchange result wrong");

  AST_DIGIT_LOW: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL2
    OP_I == EXD_OP_DIGIT_EXCH |=> (ACC_O & 8'h0f) == ($past(IND_DATA_I) & 8'h0f)
      && (WR_DATA_O & 8'h0f) == ($past(ACC_O) & 8'h0f))
    else $error("digit exchange low nibble wrong");

  AST_DIGIT_HIGH: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL3
    OP_I == EXD_OP_DIGIT_EXCH |=> (ACC_O & 8'hf0) == ($past(ACC_O) & 8'hf0)
      && (WR_DATA_O & 8'hf0) == ($past(IND_DATA_I) & 8'hf0))
    else $error("digit exchange touched high nibble");

  AST_DIGIT_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL2
    OP_I == EXD_OP_DIGIT_EXCH
      |=> WR_EN_O && WR_IND_O && WR_ADDR_O == $past(PTR_ADDR_I))
    else $error("digit exchange write strobe wrong");

  AST_EXCH_PULSE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL8
    OP_I == EXD_OP_BYTE_EXCH ##1 OP_I == EXD_OP_NONE
      |=> !DONE_O && !WR_EN_O && !WR_IND_O)
    else $error("exchange pulses stood too long");

  // ****************************************************************
  // Exclusive-OR checks
  // ****************************************************************

  AST_XOR_ACC: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL4
    OP_I == EXD_OP_XOR_A && SRC_I == EXD_SRC_REG
      |=> ACC_O == ($past(ACC_O) ^ $past(REG_DATA_I)) && !WR_EN_O)
    else $error("accumulator XOR wrong");

  AST_XOR_IND: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL5
    OP_I == EXD_OP_XOR_A && SRC_I == EXD_SRC_IND
      |=> ACC_O == ($past(ACC_O) ^ $past(IND_DATA_I)))
    else $error("indirect XOR source wrong");

  AST_XOR_PORT: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL6
    OP_I == EXD_OP_XOR_DIR && DIR_IS_PORT_I && SRC_I == EXD_SRC_IMM
      |=> WR_DATA_O == ($past(PORT_LATCH_I) ^ $past(IMM_DATA_I)))
    else $error("port XOR did not use latch");

  AST_XOR_MASK: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL7
    OP_I == EXD_OP_XOR_DIR && !DIR_IS_PORT_I && SRC_I != EXD_SRC_IMM
      |=> WR_EN_O && !WR_IND_O && ACC_O == $past(ACC_O)
      && WR_DATA_O == ($past(DIR_DATA_I) ^ $past(ACC_O)))
    else $error("direct XOR mask wrong");

  AST_XOR_DIRECT_SRC: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL5
    OP_I == EXD_OP_XOR_A && SRC_I == EXD_SRC_DIR && !DIR_IS_PORT_I
      |=> ACC_O == ($past(ACC_O) ^ $past(DIR_DATA_I)))
    else $error("direct XOR source wrong");

  AST_XOR_IMM_SRC: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL5
    OP_I == EXD_OP_XOR_A && SRC_I == EXD_SRC_IMM
      |=> ACC_O == ($past(ACC_O) ^ $past(IMM_DATA_I)))
    else $error("immediate XOR source wrong");

  AST_XOR_A_NO_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL4
    OP_I == EXD_OP_XOR_A |=> !WR_EN_O && !WR_IND_O && DONE_O
      && WR_ADDR_O == $past(WR_ADDR_O) && WR_DATA_O == $past(WR_DATA_O))
    else $error("accumulator XOR touched the write port");

  AST_XOR_DIR_IMM: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL7
    OP_I == EXD_OP_XOR_DIR && !DIR_IS_PORT_I && SRC_I == EXD_SRC_IMM
      |=> WR_EN_O && !WR_IND_O && WR_ADDR_O == $past(DIR_ADDR_I)
      && WR_DATA_O == ($past(DIR_DATA_I) ^ $past(IMM_DATA_I)))
    else $error("direct XOR immediate mask wrong");

  AST_XOR_PORT_ACC: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL6
    OP_I == EXD_OP_XOR_DIR && DIR_IS_PORT_I && SRC_I != EXD_SRC_IMM
      |=> WR_DATA_O == ($past(PORT_LATCH_I) ^ $past(ACC_O)) && ACC_O == $past(ACC_O))
    else $error("port XOR with accumulator did not use latch");

  // ****************************************************************
  // Sequencing checks
  // ****************************************************************
  AST_ONE_CYCLE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL8
    OP_I inside {EXD_OP_BYTE_EXCH, EXD_OP_DIGIT_EXCH}
      |=> DONE_O ##1 (DONE_O == ($past(OP_I) != EXD_OP_NONE)))
    else $error("exchange not done in one cycle");

  AST_DONE_WITH_OP: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL8
    DONE_O |-> $past(OP_I) != EXD_OP_NONE)
    else $error("done pulse without an instruction");

  AST_IDLE_QUIET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL8
    OP_I == EXD_OP_NONE |=> !DONE_O && !WR_EN_O && ACC_O == $past(ACC_O))
    else $error("idle cycle changed state");

endmodule : exd_datapath

`default_nettype wire

// ==== tb/exd_datapath_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module exd_datapath_tb;
  import exd_pkg::*;
  logic           clk_sys, rst_n, dir_port, wen, wind, done;
  exd_op_t        op;
  exd_src_t       src;
  logic [7:0]     ptr, ind, rdat, daddr, ddat, latch, imm, acc, wa, wd, m_acc;
  logic [25:0]    notes[$];
  logic [25:0]    n;
  logic [31:0]    seed = 32'd61296;
  int             checks = 0, miscompares = 0;
  exd_datapath dut_u (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .OP_I(op), .SRC_I(src),
    .PTR_ADDR_I(ptr), .IND_DATA_I(ind), .REG_DATA_I(rdat), .DIR_ADDR_I(daddr),
    .DIR_DATA_I(ddat), .DIR_IS_PORT_I(dir_port), .PORT_LATCH_I(latch), .IMM_DATA_I(imm),
    .ACC_O(acc), .WR_EN_O(wen), .WR_IND_O(wind), .WR_ADDR_O(wa), .WR_DATA_O(wd),
    .DONE_O(done));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // *****
  // Stimulus with expected results noted
  // *****
  logic [7:0] e_wa = 8'h00, e_wd = 8'h00, b;
  logic [1:0] w;
  task automatic issue(input exd_op_t o, input exd_src_t s);
    @(negedge clk_sys);
    op = o;
    src = s;
    {ptr, ind, rdat, daddr} = rnd();
    {dir_port, ddat, latch, imm} = 25'(rnd());
    b = dir_port ? latch : ddat;
    w = 2'h0;
    case (o)
      EXD_OP_BYTE_EXCH: begin
        e_wa = ptr; e_wd = m_acc; m_acc = ind; w = 2'h3;
      end
      EXD_OP_DIGIT_EXCH: begin
        e_wa = ptr; e_wd = {ind[7:4], m_acc[3:0]}; m_acc = {m_acc[7:4], ind[3:0]}; w = 2'h3;
      end
      EXD_OP_XOR_A:
        m_acc ^= (s == EXD_SRC_REG) ? rdat : (s == EXD_SRC_DIR) ? b
               : (s == EXD_SRC_IND) ? ind : imm;
      EXD_OP_XOR_DIR: begin
        e_wa = daddr; e_wd = b ^ ((s == EXD_SRC_IMM) ? imm : m_acc); w = 2'h2;
      end
      default: ;
    endcase
    if (o != EXD_OP_NONE) notes.push_back({m_acc, w, e_wa, e_wd});
  endtask : issue
  // *****
  // Checking
  // *****
  always @(posedge clk_sys) begin
    #1;
    if (done === 1'b1) begin
      if (notes.size() == 0) `CHK("spare done", 1'b0, 1'b1)
      else begin
        n = notes.pop_front();
        `CHK("acc", n[25:18], acc)
        `CHK("wr_en", n[17], wen)
        `CHK("wr_ind", n[16], wind)
        `CHK("wr_addr", n[15:8], wa)
        `CHK("wr_data", n[7:0], wd)
      end
    end
  end
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    op = EXD_OP_NONE;
    src = EXD_SRC_REG;
    {ptr, ind, rdat, daddr, ddat, latch, imm, dir_port} = '0;
    m_acc = 8'h00;
    repeat (16) @(negedge clk_sys);
    `CHK("rst outs", {EXD_ACC_RST, 2'h0, EXD_WADDR_RST, EXD_WDATA_RST, 1'b0}, {acc, wen, wind, wa, wd, done})
    rst_n = 1'b1;
    for (int o = 1; o < 5; o++) begin
      for (int s = 0; s < 4; s++) issue(exd_op_t'(o), exd_src_t'(s));
    end
    issue(EXD_OP_NONE, EXD_SRC_REG);
    rst_n = 1'b0;
    #1;
    `CHK("mid rst outs", {EXD_ACC_RST, 2'h0, EXD_WADDR_RST, EXD_WDATA_RST, 1'b0}, {acc, wen, wind, wa, wd, done})
    {m_acc, e_wa, e_wd} = {EXD_ACC_RST, EXD_WADDR_RST, EXD_WDATA_RST};
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 300; i++) issue(exd_op_t'(3'(rnd() % 5)), exd_src_t'(2'(rnd())));
    issue(EXD_OP_NONE, EXD_SRC_REG);
    repeat (4) @(negedge clk_sys);
    `CHK("pending", 0, notes.size())
    give_verdict();
  end
endmodule : exd_datapath_tb
`default_nettype wire
